// ===== shared/srt_pkg.sv
// Shared constants for the two-channel 16-bit reload timer
package srt_pkg;
	localparam int unsigned CNT_W       = 16;
	localparam int unsigned NUM_CH      = 2;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;

	// Byte addresses of the register words
	localparam logic [11:0] ADDR_CTRL0   = 12'h000;
	localparam logic [11:0] ADDR_RELOAD0 = 12'h004;
	localparam logic [11:0] ADDR_COUNT0  = 12'h008;
	localparam logic [11:0] ADDR_CTRL1   = 12'h010;
	localparam logic [11:0] ADDR_RELOAD1 = 12'h014;
	localparam logic [11:0] ADDR_COUNT1  = 12'h018;
	localparam logic [11:0] ADDR_STATUS  = 12'h020;
	localparam logic [11:0] ADDR_MASK    = 12'h024;
	localparam logic [11:0] ADDR_XFER    = 12'h028;

	// Control word fields
	localparam int unsigned CTRL_START   = 0;
	localparam int unsigned CTRL_RELOAD  = 1;
	localparam int unsigned CTRL_EVENT   = 2;
	localparam int unsigned CTRL_CLK_LO  = 3;
	localparam int unsigned CTRL_EDGE_LO = 5;
	localparam int unsigned CTRL_RUN     = 8;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;

	// Internal prescaler divide ratios (log2); PRE_SHIFT2 is unused, tick 2 divides by 64
	localparam int unsigned PRE_SHIFT0   = 1;
	localparam int unsigned PRE_SHIFT1   = 3;
	localparam int unsigned PRE_SHIFT2   = 5;
	localparam int unsigned PRE_W        = 6;

	// Edge selection codes
	localparam logic [1:0]  EDGE_NONE    = 2'b00;
	localparam logic [1:0]  EDGE_RISE    = 2'b01;
	localparam logic [1:0]  EDGE_FALL    = 2'b10;
	localparam logic [1:0]  EDGE_BOTH    = 2'b11;
endpackage

// ===== src/srt_channel.sv
// One reload timer channel: counter, source select, mode control
`timescale 1ns/1ns
module srt_channel
	import srt_pkg::*;
#(
	parameter int unsigned W = CNT_W
)
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	// Configuration
	input  wire logic         start_pulse,
	input  wire logic         stop_pulse,
	input  wire logic         reload_mode,
	input  wire logic         event_mode,
	input  wire logic   [1:0] clk_sel,
	input  wire logic   [1:0] edge_sel,
	input  wire logic [W-1:0] reload_val,
	// Count sources
	input  wire logic   [2:0] tick,
	input  wire logic         evt_sync,
	// State
	output logic      [W-1:0] count_reg,
	output logic              run_reg,
	output logic              underflow
);
	logic         evt_prev_reg;
	logic         load_reg;
	logic         rise;
	logic         fall;
	logic         edge_hit;
	logic         int_hit;
	logic         dec_en;
	logic [W-1:0] count_next;

	assign rise     = evt_sync & ~evt_prev_reg;
	assign fall     = ~evt_sync & evt_prev_reg;
	assign edge_hit = (edge_sel[0] & rise) | (edge_sel[1] & fall);
	assign int_hit  = (clk_sel == 2'd0) ? tick[0] :
	                  (clk_sel == 2'd1) ? tick[1] : tick[2];
	// A control write in the same cycle wins, so no flag without a wrap
	assign dec_en   = run_reg & ~load_reg & ~start_pulse & ~stop_pulse
	                & (event_mode ? edge_hit : int_hit);
	assign underflow  = dec_en & (count_reg == {W{1'b0}});
	assign count_next = count_reg - {{(W-1){1'b0}}, 1'b1};

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			evt_prev_reg <= 1'b0;
		else
			evt_prev_reg <= evt_sync;
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			run_reg   <= 1'b0;
			load_reg  <= 1'b0;
			count_reg <= '0;
		end
		else if (stop_pulse)
		begin
			run_reg  <= 1'b0;
			load_reg <= 1'b0;
		end
		else if (start_pulse)
		begin
			run_reg  <= 1'b1;
			load_reg <= 1'b1;
		end
		else if (load_reg)
		begin
			load_reg  <= 1'b0;
			count_reg <= reload_val;
		end
		else if (underflow)
		begin
			count_reg <= reload_mode ? reload_val : count_next;
			run_reg   <= reload_mode;
		end
		else if (dec_en)
			count_reg <= count_next;
	end

	a_load_before_dec: assert property (@(posedge ref_clk) disable iff (sys_rst)
		start_pulse && !stop_pulse |=> load_reg && !underflow)
		else $error("count moved before load");
	a_oneshot_stops: assert property (@(posedge ref_clk) disable iff (sys_rst)
		underflow && !reload_mode && !start_pulse && !stop_pulse |=> !run_reg)
		else $error("one-shot kept running");
	a_reload_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
		underflow && reload_mode && !start_pulse && !stop_pulse
		|=> run_reg && count_reg == $past(reload_val))
		else $error("no reload after underflow");
	a_wrap_value: assert property (@(posedge ref_clk) disable iff (sys_rst)
		underflow && !reload_mode && !start_pulse && !stop_pulse
		|=> count_reg == CNT_ALL_ONE[W-1:0])
		else $error("underflow did not wrap");
	a_underflow_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		underflow |-> count_reg == CNT_ZERO[W-1:0] && run_reg)
		else $error("underflow off zero");
	a_idle_frozen: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!run_reg && !start_pulse |=> $stable(count_reg))
		else $error("stopped counter moved");
	a_event_source: assert property (@(posedge ref_clk) disable iff (sys_rst)
		run_reg && !load_reg && event_mode && !edge_hit && !start_pulse && !stop_pulse
		|=> $stable(count_reg))
		else $error("event counter moved without edge");
endmodule

// ===== src/srt_prescaler.sv
// Free-running prescaler producing three internal tick pulses
`timescale 1ns/1ns
module srt_prescaler
	import srt_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Tick outputs
	output logic      [2:0] tick
);
	logic [PRE_W-1:0] div_reg;
	logic [PRE_W-1:0] div_next;
	logic [PRE_W-1:0] all_ones;

	assign all_ones = '1;
	assign div_next = div_reg + {{(PRE_W-1){1'b0}}, 1'b1};
	assign tick[0]  = &div_reg[PRE_SHIFT0-1:0];
	assign tick[1]  = &div_reg[PRE_SHIFT1-1:0];
	assign tick[2]  = div_reg == all_ones;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			div_reg <= '0;
		else
			div_reg <= div_next;
	end
endmodule

// ===== src/srt_reload_timer.sv
// Two-channel 16-bit reload timer with APB registers
`timescale 1ns/1ns
// What this block does
// - Internal mode decrements once per tick of one of three prescaled clocks.
// - Event mode decrements once per selected edge on the event pin.
// - Each channel counts from exactly one source, internal or event.
// - Underflow is the step down from 0000H (to FFFFH in one-shot, to the reload value in reload mode), flagged only then.
// - From reload value N, underflow comes after N plus 1 counts.
// - Reload mode reloads on underflow and keeps counting.
// - One-shot mode stops at first underflow until software restarts.
// - Underflow raises an interrupt or a hardware transfer request.
// - Two identical independent channels with own counter, reload, mode, interrupt.
// - Underflow is offered as a baud clock source to serial ports.
module srt_reload_timer
	import srt_pkg::*;
(
	// Clock and reset
	input  wire logic               ref_clk,
	input  wire logic               sys_rst,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic        [11:0] paddr,
	input  wire logic        [31:0] pwdata,
	output logic             [31:0] prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Event input pins
	input  wire logic  [NUM_CH-1:0] evt_in,
	// Interrupt and transfer requests
	output logic                    irq,
	output logic       [NUM_CH-1:0] xfer_req,
	// Serial baud clock source
	output logic       [NUM_CH-1:0] baud_tick
);
	logic [2:0]        tick;
	logic [NUM_CH-1:0] evt_s1_reg;
	logic [NUM_CH-1:0] evt_s2_reg;
	logic [7:0]        ctrl_reg   [NUM_CH];
	logic [CNT_W-1:0]  reload_reg [NUM_CH];
	logic [CNT_W-1:0]  count_w    [NUM_CH];
	logic [NUM_CH-1:0] run_w;
	logic [NUM_CH-1:0] uf_w;
	logic [NUM_CH-1:0] start_w;
	logic [NUM_CH-1:0] stop_w;
	logic [NUM_CH-1:0] status_reg;
	logic [NUM_CH-1:0] status_next;
	logic [NUM_CH-1:0] mask_reg;
	logic [NUM_CH-1:0] xfer_sel_reg;
	logic [NUM_CH-1:0] baud_reg;
	logic [NUM_CH-1:0] pending;
	logic [31:0]       rdata_mux;
	logic              wr_en;
	logic              rd_en;
	logic              hit;
	logic              sel_ctrl0;
	logic              sel_ctrl1;
	logic              sel_rel0;
	logic              sel_rel1;
	logic              sel_status;
	logic              sel_mask;
	logic              sel_xfer;

	// Single-wait-free APB access
	assign pready    = 1'b1;
	assign wr_en     = psel & penable & pwrite;
	assign rd_en     = psel & penable & ~pwrite;
	assign sel_ctrl0 = paddr == ADDR_CTRL0;
	assign sel_ctrl1 = paddr == ADDR_CTRL1;
	assign sel_rel0  = paddr == ADDR_RELOAD0;
	assign sel_rel1  = paddr == ADDR_RELOAD1;
	assign sel_status = paddr == ADDR_STATUS;
	assign sel_mask  = paddr == ADDR_MASK;
	assign sel_xfer  = paddr == ADDR_XFER;
	assign hit = sel_ctrl0 | sel_ctrl1 | sel_rel0 | sel_rel1 | sel_status
	           | sel_mask | sel_xfer | (paddr == ADDR_COUNT0) | (paddr == ADDR_COUNT1);
	assign pslverr = psel & penable & ~hit;

	// Start written as one, stop written as zero to the start bit
	assign start_w[0] = wr_en & sel_ctrl0 & pwdata[CTRL_START];
	assign stop_w[0]  = wr_en & sel_ctrl0 & ~pwdata[CTRL_START];
	assign start_w[1] = wr_en & sel_ctrl1 & pwdata[CTRL_START];
	assign stop_w[1]  = wr_en & sel_ctrl1 & ~pwdata[CTRL_START];

	srt_prescaler u_pre (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.tick    (tick)
	);

	// Event pins pass two flops first
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			evt_s1_reg <= '0;
			evt_s2_reg <= '0;
		end
		else
		begin
			evt_s1_reg <= evt_in;
			evt_s2_reg <= evt_s1_reg;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_ch
			srt_channel #(.W(CNT_W)) u_ch (
				.ref_clk     (ref_clk),
				.sys_rst     (sys_rst),
				.start_pulse (start_w[g]),
				.stop_pulse  (stop_w[g]),
				.reload_mode (ctrl_reg[g][CTRL_RELOAD]),
				.event_mode  (ctrl_reg[g][CTRL_EVENT]),
				.clk_sel     (ctrl_reg[g][CTRL_CLK_LO +: 2]),
				.edge_sel    (ctrl_reg[g][CTRL_EDGE_LO +: 2]),
				.reload_val  (reload_reg[g]),
				.tick        (tick),
				.evt_sync    (evt_s2_reg[g]),
				.count_reg   (count_w[g]),
				.run_reg     (run_w[g]),
				.underflow   (uf_w[g])
			);
		end
	endgenerate

	// Config registers
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_reg[0]   <= CTRL_RESET;
			ctrl_reg[1]   <= CTRL_RESET;
			reload_reg[0] <= CNT_ZERO;
			reload_reg[1] <= CNT_ZERO;
			mask_reg      <= '0;
			xfer_sel_reg  <= '0;
		end
		else
		begin
			if (wr_en && sel_ctrl0)
				ctrl_reg[0] <= pwdata[7:0];
			if (wr_en && sel_ctrl1)
				ctrl_reg[1] <= pwdata[7:0];
			if (wr_en && sel_rel0)
				reload_reg[0] <= pwdata[CNT_W-1:0];
			if (wr_en && sel_rel1)
				reload_reg[1] <= pwdata[CNT_W-1:0];
			if (wr_en && sel_mask)
				mask_reg <= pwdata[NUM_CH-1:0];
			if (wr_en && sel_xfer)
				xfer_sel_reg <= pwdata[NUM_CH-1:0];
		end
	end

	// Sticky flags: set wins over write-one-to-clear
	assign status_next = (status_reg & ~({NUM_CH{wr_en & sel_status}} & pwdata[NUM_CH-1:0]))
	                   | uf_w;

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end

	// Requests routed to CPU or to transfer service
	assign pending  = status_reg & mask_reg;
	assign irq      = |(pending & ~xfer_sel_reg);
	assign xfer_req = pending & xfer_sel_reg;

	// Baud clock pulse, registered
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			baud_reg <= '0;
		else
			baud_reg <= uf_w;
	end
	assign baud_tick = baud_reg;

	// Read data mux
	always_comb
	begin
		rdata_mux = 32'h0000_0000;
		unique case (paddr)
			ADDR_CTRL0:   rdata_mux = {23'h0, run_w[0], ctrl_reg[0]};
			ADDR_CTRL1:   rdata_mux = {23'h0, run_w[1], ctrl_reg[1]};
			ADDR_RELOAD0: rdata_mux = {16'h0, reload_reg[0]};
			ADDR_RELOAD1: rdata_mux = {16'h0, reload_reg[1]};
			ADDR_COUNT0:  rdata_mux = {16'h0, count_w[0]};
			ADDR_COUNT1:  rdata_mux = {16'h0, count_w[1]};
			ADDR_STATUS:  rdata_mux = {30'h0, status_reg};
			ADDR_MASK:    rdata_mux = {30'h0, mask_reg};
			ADDR_XFER:    rdata_mux = {30'h0, xfer_sel_reg};
			default:      rdata_mux = 32'h0000_0000;
		endcase
	end
	assign prdata = rd_en ? rdata_mux : 32'h0000_0000;

	a_flag_sticks: assert property (@(posedge ref_clk) disable iff (sys_rst)
		status_reg[0] && !(wr_en && sel_status && pwdata[0]) |=> status_reg[0])
		else $error("flag dropped without clear");
	a_flag_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		uf_w[1] |=> status_reg[1] ##0 baud_tick[1])
		else $error("underflow not flagged");
	a_irq_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
		irq |-> |(status_reg & mask_reg & ~xfer_sel_reg))
		else $error("irq without enabled flag");
endmodule

// ===== verification/srt_evt_src.sv
// Event pulse source driving the timer event pins
`timescale 1ns/1ns
module srt_evt_src
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// Toggle request per pin
	input  wire logic [1:0] fire,
	// Event pins
	output logic      [1:0] pin
);
	// Each request flips its pin, so edges alternate rise and fall
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			pin <= 2'b00;
		else
			pin <= pin ^ fire;
endmodule

// ===== verification/tb_srt_reload_timer.sv
// Testbench for the two-channel reload timer
`timescale 1ns/1ns
module tb_srt_reload_timer
	import srt_pkg::*;
;
	logic        ref_clk, sys_rst, psel, penable, pwrite, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, rdat, prdata;
	logic [1:0]  fire, evt_in, xfer_req, baud_tick;
	logic        pready, pslverr, irq;
	int          bad_count = 0;
	int          total_checks = 0;
	int          bt_cnt [2] = '{0, 0};

	srt_reload_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_in(evt_in),
		.irq(irq), .xfer_req(xfer_req), .baud_tick(baud_tick));
	srt_evt_src src (.ref_clk(ref_clk), .sys_rst(sys_rst), .fire(fire), .pin(evt_in));

	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
		foreach (bt_cnt[i])
			if (baud_tick[i] === 1'b1)
				bt_cnt[i]++;

	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			chk("pready", 32'h1, 32'h0);
			finish_test();
		end
		rdat = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_st(input int b);
		int n = 0;
		do
		begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end
		while (rdat[b] !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			chk("status wait", 32'h1, 32'h0);
			finish_test();
		end
	endtask

	task pulse(input logic [1:0] f);
		@(posedge ref_clk);
		fire <= f;
		@(posedge ref_clk);
		fire <= 2'b00;
		repeat (8) @(posedge ref_clk);
	endtask

	task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask

	initial
	begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		fire = 2'b00;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd_chk("ctrl0", ADDR_CTRL0, 32'h0);
		rd_chk("status", ADDR_STATUS, 32'h0);
		chk("irq", 32'h0, irq);
		rd_chk("unmapped", 12'hFFC, 32'h0);
		chk("slverr", 32'h1, perr);
		$display("test reset done");
		// Internal clocks, one-shot, reload 3
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, ADDR_RELOAD0, 32'h3);
			apb(1'b1, ADDR_CTRL0, 32'h1 | (s << 3));
			wait_st(0);
			rd_chk("count0", ADDR_COUNT0, 32'h0000FFFF);
			apb(1'b0, ADDR_CTRL0, 32'h0);
			chk("run0", 32'h0, rdat[8]);
			apb(1'b1, ADDR_STATUS, 32'h1);
		end
		rd_chk("status clr", ADDR_STATUS, 32'h0);
		chk("baud0", 32'h4, bt_cnt[0]);
		$display("test internal done");
		// Event edges on channel 0, reload 0
		apb(1'b1, ADDR_RELOAD0, 32'h0);
		apb(1'b1, ADDR_CTRL0, 32'h25);
		pulse(2'b01);
		rd_chk("rise hit", ADDR_STATUS, 32'h1);
		apb(1'b1, ADDR_STATUS, 32'h1);
		apb(1'b1, ADDR_CTRL0, 32'h25);
		pulse(2'b01);
		rd_chk("fall skip", ADDR_STATUS, 32'h0);
		apb(1'b1, ADDR_CTRL0, 32'h45);
		pulse(2'b01);
		rd_chk("rise skip", ADDR_STATUS, 32'h0);
		pulse(2'b01);
		rd_chk("fall hit", ADDR_STATUS, 32'h1);
		apb(1'b1, ADDR_STATUS, 32'h1);
		$display("test edges done");
		// Channel 1, event both edges, reload mode, reload 2
		apb(1'b1, ADDR_RELOAD1, 32'h2);
		apb(1'b1, ADDR_CTRL1, 32'h67);
		repeat (100) @(posedge ref_clk);
		rd_chk("count1 idle", ADDR_COUNT1, 32'h2);
		pulse(2'b10);
		pulse(2'b10);
		rd_chk("count1 zero", ADDR_COUNT1, 32'h0);
		rd_chk("no flag", ADDR_STATUS, 32'h0);
		pulse(2'b10);
		rd_chk("flag1", ADDR_STATUS, 32'h2);
		rd_chk("reloaded", ADDR_COUNT1, 32'h2);
		apb(1'b0, ADDR_CTRL1, 32'h0);
		chk("run1", 32'h1, rdat[8]);
		chk("baud", 32'h1, bt_cnt[1]);
		$display("test reload done");
		// Interrupt and transfer routing
		apb(1'b1, ADDR_MASK, 32'h0);
		@(posedge ref_clk);
		chk("irq masked", 32'h0, irq);
		apb(1'b1, ADDR_MASK, 32'h2);
		@(posedge ref_clk);
		chk("irq on", 32'h1, irq);
		apb(1'b1, ADDR_XFER, 32'h2);
		@(posedge ref_clk);
		chk("irq xfer", 32'h0, irq);
		chk("xfer on", 32'h2, xfer_req);
		apb(1'b1, ADDR_STATUS, 32'h2);
		@(posedge ref_clk);
		chk("xfer off", 32'h0, xfer_req);
		$display("test interrupt done");
		finish_test();
	end
endmodule
